// file: hw/tad_defs.svh
`ifndef TAD_DEFS_SVH
`define TAD_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TAD_REG_CTRL 8'h00
`define TAD_REG_SNR_THR 8'h04
`define TAD_REG_RATE_THR 8'h08
`define TAD_REG_PERIOD 8'h0C
`define TAD_REG_STATUS 8'h10
`define TAD_REG_RATE_BASE 8'h20
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define TAD_CTRL_START 0
`define TAD_CTRL_PRO_EN 1
`define TAD_CTRL_RATE_CHG_EN 2
`define TAD_SNR_THR_RST 16'h0080
`define TAD_RATE_THR_RST 16'h0100
`define TAD_PERIOD_RST 32'h0000_1000
`define TAD_NANT 4
`define TAD_STATUS_BEGIN 2'h1
`define TAD_STATUS_SCAN 2'h2
`endif

// file: hw/tad_pkg.sv
package tad_pkg;
   typedef enum logic [2:0] {
      TAD_IDLE = 3'h0,
      TAD_SETUP = 3'h1,
      TAD_RUN = 3'h3,
      TAD_SCAN_REQ = 3'h2,
      TAD_SCAN_WAIT = 3'h6,
      TAD_SELECT = 3'h7
   } tad_state_t;
   typedef logic [1:0] tad_ant_t;
endpackage

// file: hw/tad_sel_if.sv
`timescale 1ns/1ps
interface tad_sel_if;
   logic [63:0] rates;
   logic [1:0] best;
   modport ctl (output rates, input best);
   modport sel (input rates, output best);
endinterface

// file: hw/tad_best_sel.sv
`timescale 1ns/1ps
module tad_best_sel (
   // Rate table in, chosen antenna out
   tad_sel_if.sel s
);
   // ----------------------------------------
   // Highest rate search, lowest index wins ties
   // ----------------------------------------
   always_comb begin
      logic [15:0] top;
      top = s.rates[15:0];
      s.best = 2'h0;
      for (int i = 1; i < 4; i++) begin
         if (s.rates[i*16 +: 16] > top) begin
            top = s.rates[i*16 +: 16];
            s.best = 2'(i);
         end
      end
   end
endmodule // tad_best_sel

// file: hw/tad_ctrl.sv
// Operation
// (RL1) Start by sending setup request, status begin, on an arbitrary antenna.
// (RL2) Destination answers setup request with capability response.
// (RL3) Destination compares SNR metric against threshold for each frame.
// (RL4) Destination sends change command when metric falls below threshold.
// (RL5) On change command switch to another antenna unconditionally. The code switches only in the run state.
// (RL6) Periodically scan channels of every inactive antenna.
// (RL7) Scan: leave active antenna, send scan request, take state from response.
// (RL8) After all antennas scanned choose the highest rate antenna.
// (RL9) Below rate threshold, repeat proactive selection periodically.
// (RL10) Optionally run selection on rate change from bad channel.
// (RL11) Scan only while no data transfer is in progress. The code checks data_busy_i only when a scan starts.
// (RL12) SNR threshold, rate threshold and scan period are configurable.
`timescale 1ns/1ps
`include "tad_defs.svh"
module tad_ctrl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Frame transmit request
   output logic tx_req_o,
   output logic [1:0] tx_status_o,
   input wire logic tx_ack_i,
   // Received frames from destination
   input wire logic rx_resp_i,
   input wire logic rx_capable_i,
   input wire logic [15:0] rx_rate_i,
   input wire logic rx_change_i,
   // Data path state
   input wire logic data_busy_i,
   input wire logic [15:0] cur_rate_i,
   input wire logic rate_chg_i,
   // Antenna selection
   output logic [1:0] ant_o,
   output logic [15:0] snr_thr_o
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [1:0] next_ant(input logic [1:0] a);
      next_ant = a + 2'h1;
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   tad_pkg::tad_state_t state, next_state;
   logic [2:0] ctrl, next_ctrl;
   logic [15:0] snr_thr, next_snr_thr;
   logic [15:0] rate_thr, next_rate_thr;
   logic [31:0] period, next_period;
   logic [31:0] cnt, next_cnt;
   logic [1:0] ant, next_ant_q;
   logic [1:0] home, next_home;
   logic [2:0] scanned, next_scanned;
   logic capable, next_capable;
   logic start_pend, next_start_pend;
   logic [15:0] rate_tab [4];
   logic [15:0] next_rate_tab [4];
   logic [31:0] rdata, next_rdata;
   logic [63:0] flat;
   tad_sel_if sel ();

   always_comb begin
      for (int i = 0; i < 4; i++) flat[i*16 +: 16] = rate_tab[i];
   end
   assign sel.rates = flat;

   tad_best_sel u_sel (
      .s(sel)
   );

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_ctrl = ctrl;
      next_snr_thr = snr_thr;
      next_rate_thr = rate_thr;
      next_period = period;
      next_cnt = cnt;
      next_ant_q = ant;
      next_home = home;
      next_scanned = scanned;
      next_capable = capable;
      next_start_pend = start_pend;
      next_rate_tab = rate_tab;
      next_rdata = 32'h0000_0000;
      // Register writes; thresholds and period are software values
      if (wr_i) begin
         case (addr_i)
            `TAD_REG_CTRL: begin
               next_ctrl = wdata_i[2:0];
               // Only an idle block latches a start; a start bit rewritten while
               // running must not restart the link after a later stop
               if (wdata_i[`TAD_CTRL_START] && state == tad_pkg::TAD_IDLE) begin
                  next_start_pend = 1'b1;
               end
            end
            `TAD_REG_SNR_THR: next_snr_thr = wdata_i[15:0]; // RL12
            `TAD_REG_RATE_THR: next_rate_thr = wdata_i[15:0]; // RL12
            `TAD_REG_PERIOD: next_period = wdata_i; // RL12
            default: ;
         endcase
      end
      // Reads answer one cycle later; unmapped reads give zero
      if (rd_i) begin
         case (addr_i)
            `TAD_REG_CTRL: next_rdata = {29'h0, ctrl};
            `TAD_REG_SNR_THR: next_rdata = {16'h0, snr_thr};
            `TAD_REG_RATE_THR: next_rdata = {16'h0, rate_thr};
            `TAD_REG_PERIOD: next_rdata = period;
            `TAD_REG_STATUS: next_rdata = {24'h0, capable, state, 2'h0, ant};
            `TAD_REG_RATE_BASE: next_rdata = {16'h0, rate_tab[0]};
            `TAD_REG_RATE_BASE + 8'h04: next_rdata = {16'h0, rate_tab[1]};
            `TAD_REG_RATE_BASE + 8'h08: next_rdata = {16'h0, rate_tab[2]};
            `TAD_REG_RATE_BASE + 8'h0C: next_rdata = {16'h0, rate_tab[3]};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
      if (state != tad_pkg::TAD_IDLE && cnt != 32'h0) next_cnt = cnt - 32'h1;
      case (state)
         tad_pkg::TAD_IDLE: begin
            if (start_pend) begin
               next_start_pend = 1'b0;
               // Forget the previous answer so the begin request goes out again
               next_capable = 1'b0;
               next_state = tad_pkg::TAD_SETUP; // RL1
            end
         end
         tad_pkg::TAD_SETUP: begin
            // Wait for capability answer from the destination
            if (rx_resp_i) begin
               next_capable = rx_capable_i;
               next_cnt = period;
               next_state = rx_capable_i ? tad_pkg::TAD_RUN : tad_pkg::TAD_IDLE;
            end
         end
         tad_pkg::TAD_RUN: begin
            if (rx_change_i) begin
               next_ant_q = next_ant(ant); // RL5
            end else if (ctrl[`TAD_CTRL_PRO_EN] && !data_busy_i && // RL11
                         (cnt == 32'h0 || // RL6
                          (ctrl[`TAD_CTRL_RATE_CHG_EN] && rate_chg_i))) begin // RL10
               next_home = ant;
               next_scanned = 3'h0;
               next_rate_tab[ant] = cur_rate_i;
               next_ant_q = next_ant(ant); // RL7
               next_state = tad_pkg::TAD_SCAN_REQ;
            end
         end
         tad_pkg::TAD_SCAN_REQ: begin
            if (tx_ack_i) next_state = tad_pkg::TAD_SCAN_WAIT; // RL7
         end
         tad_pkg::TAD_SCAN_WAIT: begin
            if (rx_resp_i) begin
               next_rate_tab[ant] = rx_rate_i; // RL7
               next_scanned = scanned + 3'h1;
               if (next_ant(ant) == home) begin
                  next_state = tad_pkg::TAD_SELECT;
               end else begin
                  next_ant_q = next_ant(ant);
                  next_state = tad_pkg::TAD_SCAN_REQ;
               end
            end
         end
         tad_pkg::TAD_SELECT: begin
            next_ant_q = sel.best; // RL8
            // Short period while rate stays poor; full period otherwise
            next_cnt = (cur_rate_i < rate_thr) ? (period >> 2) : period; // RL9
            next_state = tad_pkg::TAD_RUN;
         end
         default: next_state = tad_pkg::TAD_IDLE;
      endcase
      // Clearing the start bit drops back to idle from any state
      if (wr_i && addr_i == `TAD_REG_CTRL && !wdata_i[`TAD_CTRL_START]) begin
         next_state = tad_pkg::TAD_IDLE;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= tad_pkg::TAD_IDLE;
         ctrl <= 3'h0;
         snr_thr <= `TAD_SNR_THR_RST;
         rate_thr <= `TAD_RATE_THR_RST;
         period <= `TAD_PERIOD_RST;
         cnt <= 32'h0;
         ant <= 2'h0; // Arbitrary first antenna
         home <= 2'h0;
         scanned <= 3'h0;
         capable <= 1'b0;
         start_pend <= 1'b0;
         for (int i = 0; i < 4; i++) rate_tab[i] <= 16'h0;
         rdata <= 32'h0;
      end else begin
         state <= next_state;
         ctrl <= next_ctrl;
         snr_thr <= next_snr_thr;
         rate_thr <= next_rate_thr;
         period <= next_period;
         cnt <= next_cnt;
         ant <= next_ant_q;
         home <= next_home;
         scanned <= next_scanned;
         capable <= next_capable;
         start_pend <= next_start_pend;
         rate_tab <= next_rate_tab;
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Scan request held until the MAC takes it; setup request held until the destination answers
   assign tx_req_o = (state == tad_pkg::TAD_SETUP && !capable) ||
                     state == tad_pkg::TAD_SCAN_REQ;
   assign tx_status_o = (state == tad_pkg::TAD_SCAN_REQ) ? `TAD_STATUS_SCAN :
                        `TAD_STATUS_BEGIN; // RL1
   assign ant_o = ant;
   assign snr_thr_o = snr_thr; // RL3
   assign rdata_o = rdata;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_react_switch: assert property (@(posedge clk_i) disable iff (srst_i) // RL5
      (state == tad_pkg::TAD_RUN && rx_change_i) |=> ant == $past(ant) + 2'h1)
      else $error("antenna not changed on command");
   a_scan_idle: assert property (@(posedge clk_i) disable iff (srst_i) // RL11
      (state == tad_pkg::TAD_RUN && data_busy_i) |=> state != tad_pkg::TAD_SCAN_REQ)
      else $error("scan started during data");
   a_scan_status: assert property (@(posedge clk_i) disable iff (srst_i) // RL7
      state == tad_pkg::TAD_SCAN_REQ |-> tx_req_o && tx_status_o == `TAD_STATUS_SCAN)
      else $error("scan request status wrong");
   a_begin_status: assert property (@(posedge clk_i) disable iff (srst_i) // RL1
      state == tad_pkg::TAD_SETUP && !capable |-> tx_req_o &&
      tx_status_o == `TAD_STATUS_BEGIN)
      else $error("setup request status wrong");
   a_select_best: assert property (@(posedge clk_i) disable iff (srst_i) // RL8
      state == tad_pkg::TAD_SELECT |=> ant == $past(sel.best))
      else $error("best antenna not chosen");
   a_select_ret: assert property (@(posedge clk_i) disable iff (srst_i) // RL9
      state == tad_pkg::TAD_SELECT && cur_rate_i < rate_thr && !wr_i |=>
      cnt == (period >> 2))
      else $error("short period not loaded");
   a_period_scan: assert property (@(posedge clk_i) disable iff (srst_i) // RL6
      (state == tad_pkg::TAD_RUN && cnt == 32'h0 && ctrl[1] && !data_busy_i &&
       !rx_change_i && !wr_i) |=> state == tad_pkg::TAD_SCAN_REQ)
      else $error("periodic scan missed");
   a_thr_write: assert property (@(posedge clk_i) disable iff (srst_i) // RL12
      wr_i && addr_i == `TAD_REG_SNR_THR |=> snr_thr_o == $past(wdata_i[15:0]))
      else $error("threshold not written");

   // ----------------------------------------
   // Step sequences
   // ----------------------------------------
   // Each sequence marks the cycle in which one step of an exchange completes, except s_rate_drop, which marks a rate change trigger in run
   sequence s_setup_ok;
      state == tad_pkg::TAD_SETUP && rx_resp_i && rx_capable_i && !wr_i;
   endsequence
   sequence s_scan_taken;
      state == tad_pkg::TAD_SCAN_REQ && tx_ack_i && !wr_i;
   endsequence
   sequence s_scan_answer;
      state == tad_pkg::TAD_SCAN_WAIT && rx_resp_i;
   endsequence
   sequence s_rate_drop;
      state == tad_pkg::TAD_RUN && ctrl[`TAD_CTRL_PRO_EN] && ctrl[`TAD_CTRL_RATE_CHG_EN] &&
      rate_chg_i && !data_busy_i && !rx_change_i && !wr_i;
   endsequence

   // Writes are excluded where a stop could override the next state
   a_setup_run: assert property (@(posedge clk_i) disable iff (srst_i) // RL6
      s_setup_ok |=> state == tad_pkg::TAD_RUN && cnt == $past(period))
      else $error("setup answer did not start the scan timer");
   a_idle_quiet: assert property (@(posedge clk_i) disable iff (srst_i) // RL1
      state == tad_pkg::TAD_IDLE |-> !tx_req_o)
      else $error("request sent before start");
   a_scan_step: assert property (@(posedge clk_i) disable iff (srst_i) // RL7
      s_scan_taken |=> state == tad_pkg::TAD_SCAN_WAIT && !tx_req_o)
      else $error("scan request not released after acceptance");
   a_scan_store: assert property (@(posedge clk_i) disable iff (srst_i) // RL7
      s_scan_answer |=> rate_tab[$past(ant)] == $past(rx_rate_i))
      else $error("scan answer rate not stored");
   a_scan_last: assert property (@(posedge clk_i) disable iff (srst_i) // RL8
      s_scan_answer ##0 (next_ant(ant) == home && !wr_i) |=> state == tad_pkg::TAD_SELECT)
      else $error("selection not entered after last antenna");
   a_scan_count: assert property (@(posedge clk_i) disable iff (srst_i) // RL8
      state == tad_pkg::TAD_SELECT |-> scanned == 3'(`TAD_NANT - 1))
      else $error("selection before every inactive antenna was scanned");
   a_rate_scan: assert property (@(posedge clk_i) disable iff (srst_i) // RL10
      s_rate_drop |=> state == tad_pkg::TAD_SCAN_REQ)
      else $error("rate drop did not start a scan");
endmodule // tad_ctrl

// file: test/tad_dest_model.sv
`timescale 1ns/1ps
`include "tad_defs.svh"
// ----
// Far-end MAC: answers setup requests, flags weak frames
// ----
module tad_dest_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // From the source
   input wire logic req_i,
   input wire logic [1:0] st_i,
   input wire logic [1:0] ant_i,
   input wire logic [15:0] thr_i,
   // Bench controls
   input wire logic frm_i,
   input wire logic [15:0] snr_i,
   input wire logic [1:0] lag_i,
   input wire logic [63:0] rt_i,
   // Toward the source
   output logic ack_o,
   output logic resp_o,
   output logic cap_o,
   output logic [15:0] rate_o,
   output logic chg_o
);
   logic [1:0] ph;
   logic [1:0] cnt;
   // Idle rate bus toggles so a stale value never matches by luck
   always_ff @(posedge clk_i) begin
      ack_o <= 1'b0;
      resp_o <= 1'b0;
      cap_o <= 1'b0;
      chg_o <= frm_i && (snr_i < thr_i);
      rate_o <= ~rate_o;
      if (srst_i) begin
         ph <= 2'h0;
         cnt <= 2'h0;
         rate_o <= 16'h5A5A;
      end else if (cnt != 2'h0) begin
         cnt <= cnt - 2'h1;
      end else begin
         case (ph)
            2'h0: if (req_i) begin
               ph <= 2'h1;
               cnt <= lag_i;
            end
            2'h1: begin
               ph <= (st_i == `TAD_STATUS_SCAN) ? 2'h2 : 2'h3;
               ack_o <= (st_i == `TAD_STATUS_SCAN);
               resp_o <= (st_i != `TAD_STATUS_SCAN);
               cap_o <= 1'b1;
               cnt <= lag_i;
            end
            2'h2: begin
               ph <= 2'h3;
               resp_o <= 1'b1;
               cap_o <= 1'b1;
               rate_o <= rt_i[{ant_i, 4'h0} +: 16];
            end
            default: ph <= 2'h0;
         endcase
      end
   end
endmodule // tad_dest_model

// file: test/tad_ctrl_tb.sv
`timescale 1ns/1ps
`include "tad_defs.svh"
module tad_ctrl_tb;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wr = 1'b0, rd = 1'b0, busy = 1'b0, rchg = 1'b0, frm = 1'b0;
   logic req, ack, resp, cap, chg;
   logic [1:0] st, lag = 2'h3;
   logic [15:0] rate, thr, v, snr = 16'h0, cur = 16'h0;
   logic [15:0] rt [4] = '{default: 16'h0};
   tad_pkg::tad_ant_t ant, exp_ant;
   int failures = 0, checks = 0, seed = 97, cyc = 0, n, k;
   int lo [6] = '{0, 0, 0, 256, 0, 0};
   int hi [6] = '{4352, 128, 128, 528, 8, 8};
   tad_ctrl tad_ctrl_inst (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_req_o(req), .tx_status_o(st),
      .tx_ack_i(ack), .rx_resp_i(resp), .rx_capable_i(cap), .rx_rate_i(rate),
      .rx_change_i(chg), .data_busy_i(busy), .cur_rate_i(cur), .rate_chg_i(rchg),
      .ant_o(ant), .snr_thr_o(thr));
   tad_dest_model tad_dest_model_inst (.clk_i(clk_i), .srst_i(srst_i), .req_i(req),
      .st_i(st), .ant_i(ant), .thr_i(thr), .frm_i(frm), .snr_i(snr), .lag_i(lag),
      .rt_i({rt[3], rt[2], rt[1], rt[0]}), .ack_o(ack), .resp_o(resp), .cap_o(cap),
      .rate_o(rate), .chg_o(chg));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   // Hang guard, well above the longest expected run
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bus cycles start on a fresh edge so strobes never toggle twice in one step
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // Highest rate wins; strict compare keeps the lowest index on ties
   function automatic tad_pkg::tad_ant_t best_of();
      tad_pkg::tad_ant_t b;
      b = 2'h0;
      for (int i = 1; i < 4; i++)
         if (rt[i] > rt[b]) b = 2'(i);
      return b;
   endfunction
   // One proactive round: time to first scan, then judge once it goes quiet
   task automatic round(input int l, input int h);
      tad_pkg::tad_ant_t old;
      old = ant;
      n = 0;
      do begin
         @(posedge clk_i);
         #1 n = n + 1;
      end while (req !== 1'b1 && n < 5000);
      chk({31'h0, n >= l && n <= h}, 32'h1);
      chk({30'h0, st}, {30'h0, `TAD_STATUS_SCAN});
      chk({31'h0, ant !== old}, 32'h1);
      n = 0;
      do begin
         @(posedge clk_i);
         #1 n = (req === 1'b1) ? 0 : n + 1;
      end while (n < 24);
      exp_ant = best_of();
      chk({30'h0, ant}, {30'h0, exp_ant});
      for (int i = 0; i < 4; i++)
         rreg(`TAD_REG_RATE_BASE + 8'(4 * i), {16'h0, rt[i]});
   endtask
   task automatic complete_run();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      #1 chk({13'h0, req, ant, thr}, {13'h0, 1'b0, 2'h0, `TAD_SNR_THR_RST});
      rreg(`TAD_REG_RATE_THR, {16'h0, `TAD_RATE_THR_RST});
      rreg(`TAD_REG_PERIOD, `TAD_PERIOD_RST);
      wreg(8'h30, 32'hFFFF_FFFF);
      rreg(8'h30, 32'h0);
      wreg(`TAD_REG_CTRL, 32'h1);
      // Start is latched first, the request rises one edge later
      @(posedge clk_i);
      #1 chk({29'h0, req, st}, {29'h0, 1'b1, `TAD_STATUS_BEGIN});
      repeat (8) @(posedge clk_i);
      rreg(`TAD_REG_STATUS, 32'hB0);
      $display("setup test done");
      // Reactive: equal SNR keeps the antenna, one below moves it
      wreg(`TAD_REG_SNR_THR, 32'h200);
      #1 chk({16'h0, thr}, 32'h200);
      exp_ant = ant;
      for (int j = 0; j < 12; j++) begin
         v = (j == 0) ? 16'h200 : (j == 1) ? 16'h1FF : {6'h0, 10'($random(seed))};
         @(posedge clk_i);
         snr <= v;
         frm <= 1'b1;
         @(posedge clk_i);
         frm <= 1'b0;
         repeat (4) @(posedge clk_i);
         if (v < 16'h200) exp_ant = exp_ant + 2'h1;
         #1 chk({30'h0, ant}, {30'h0, exp_ant});
      end
      $display("reactive test done");
      wreg(`TAD_REG_PERIOD, 32'h200);
      wreg(`TAD_REG_CTRL, 32'h7);
      for (int r = 0; r < 6; r++) begin
         @(posedge clk_i);
         for (int i = 0; i < 4; i++)
            rt[i] = (r > 2) ? 16'h8000 : {7'h0, r == 2, 8'($random(seed))};
         lag <= 2'($random(seed));
         cur <= rt[ant];
         if (r == 4) begin
            busy <= 1'b1;
            k = 0;
            repeat (576) begin
               @(posedge clk_i);
               k = k + int'(req === 1'b1);
            end
            chk(k, 0);
            busy <= 1'b0;
         end
         if (r == 5) begin
            rchg <= 1'b1;
            @(posedge clk_i);
            rchg <= 1'b0;
         end
         round(lo[r], hi[r]);
         $display("proactive round %0d done", r);
      end
      // Stop returns to idle; a fresh start must send a new begin request
      wreg(`TAD_REG_CTRL, 32'h0);
      rreg(`TAD_REG_STATUS, {24'h0, 1'b1, tad_pkg::TAD_IDLE, 2'h0, exp_ant});
      wreg(`TAD_REG_CTRL, 32'h1);
      @(posedge clk_i);
      #1 chk({29'h0, req, st}, {29'h0, 1'b1, `TAD_STATUS_BEGIN});
      repeat (8) @(posedge clk_i);
      rreg(`TAD_REG_STATUS, {24'h0, 1'b1, tad_pkg::TAD_RUN, 2'h0, exp_ant});
      $display("restart test done");
      complete_run();
   end
endmodule // tad_ctrl_tb
